// ### src/usd_regs_defs.vh
// Operation
// - Status bit 7 reads one while a DMA transfer runs, zero after.
// - The fall of the DMA activity bit raises no interrupt request.
// - Status bits 6, 5, 4 latch bus reset, SOF received, DMA done.
// - Status bits 3 to 0 latch endpoint 3 to 0 transfer done.
// - Current-set bits 3 to 0 show ping-pong set per endpoint, 0=a, 1=b.
// - Control 2 bit 7 one selects host role, zero selects peripheral.
// - Control 2 bit 6 one swaps data line polarity for low speed.
// - Frame low register bits 7 to 1 hold seven frame bits; bit 0 undefined.
// - Both frame registers refresh on every received start-of-frame packet.
// - Frame high register bits 7 to 4 hold four further frame bits.
// - Sixteen-bit DMA byte count split into low and high registers.
// - The count is the total bytes moved in one DMA operation.
// - Writing count high starts DMA only when DMA enable is set.
// - Endpoint three is served through DMA while DMA enable is set.
// - Writing status clears flags whose written bit is one.
// - Enable bits only gate flags onto the request; flags unaffected.
// - Control 1 bit 1 enables DMA, bit 2 sets direction, one reads.
`ifndef USD_REGS_DEFS_VH
`define USD_REGS_DEFS_VH
`define USD_A_CTRL1       8'h05
`define USD_A_INT_EN      8'h06
`define USD_A_INT_STAT    8'h0d
`define USD_A_CUR_SET     8'h0e
`define USD_A_CTRL2       8'h0f
`define USD_A_SOF_LO      8'h15
`define USD_A_SOF_HI      8'h16
`define USD_A_CNT_LO      8'h35
`define USD_A_CNT_HI      8'h36
`define USD_B_DMA_ACT     7
`define USD_B_BUS_RST     6
`define USD_B_SOF         5
`define USD_B_DMA_DONE    4
`define USD_B_DMA_EN      1
`define USD_B_DMA_DIR     2
`define USD_B_HOST        7
`define USD_B_SWAP        6
`define USD_CTRL2_MASK    8'hc0
`define USD_ZERO8         8'h00
`define USD_ZERO16        16'h0000
`define USD_ONE16         16'h0001
`define USD_EP_W          4
`define USD_B_SPEED       5
`define USD_FLAG_N        7
`define USD_FLAGS         6:0
`define USD_FRM_LO        6:0
`define USD_FRM_HI        10:7
`define USD_LO_BYTE       7:0
`define USD_HI_BYTE       15:8
`define USD_ZERO7         7'h00
`define USD_ZERO4         4'h0
`endif

// ### src/usd_flag.v
`timescale 1ns/10ps
`include "usd_regs_defs.vh"
module usd_flag (
    input  wire i_ref_clk,
    input  wire i_rst_n,
    input  wire i_set,
    input  wire i_clr,
    output reg  o_flag
);
    // Set beats clear so a same-cycle event is kept
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule // usd_flag

// ### src/usd_regs.v
`timescale 1ns/10ps
`include "usd_regs_defs.vh"
module usd_regs (
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    input  wire        i_cs_n,
    input  wire        i_wr_n,
    input  wire        i_rd_n,
    input  wire        i_a0,
    input  wire [7:0]  i_data,
    input  wire        i_bus_reset_seen,
    input  wire        i_sof_seen,
    input  wire [10:0] i_sof_frame,
    input  wire [3:0]  i_ep_done,
    input  wire [3:0]  i_ep_set_sel,
    input  wire        i_dma_ack_n,
    output reg  [7:0]  o_data,
    output reg         o_data_oe,
    output reg         o_interrupt_request_out,
    output reg         o_host_mode,
    output reg         o_line_swap,
    output reg         o_speed_select_bit,
    output reg         o_dma_req_n,
    output reg         o_dma_dir_read,
    output reg         o_endpoint_three_dma
);
    ////////////////////////////////////////////////////////////////////
    reg  [7:0]  addr_r;
    reg  [7:0]  ctrl1_r;
    reg  [7:0]  int_en_r;
    reg  [7:0]  ctrl2_r;
    reg  [3:0]  cur_set_r;
    reg  [6:0]  sof_lo_r;
    reg  [3:0]  sof_hi_r;
    reg  [15:0] cnt_r;
    reg  [15:0] left_r;
    reg  [15:0] left_nxt;
    reg         dma_act_r;
    reg         dma_act_nxt;
    reg         dma_fin;
    reg         wr_d_r;
    reg         rd_d_r;
    wire        wr_now;
    wire        rd_now;
    wire        wr_reg;
    wire        stat_clr;
    wire [7:0]  flag_set;
    wire [6:0]  flags;
    wire [7:0]  status;
    reg  [7:0]  rd_val;

    // Strobe falling edges so a long cycle acts once
    assign wr_now   = !i_cs_n && !i_wr_n && !wr_d_r;
    assign rd_now   = !i_cs_n && !i_rd_n && !rd_d_r;
    assign wr_reg   = wr_now && i_a0;
    assign stat_clr = wr_reg && (addr_r == `USD_A_INT_STAT);

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_d_r <= 1'b0;
            rd_d_r <= 1'b0;
        end else begin
            wr_d_r <= !i_cs_n && !i_wr_n;
            rd_d_r <= !i_cs_n && !i_rd_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address phase with A0 low, data phase with A0 high
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_r   <= `USD_ZERO8;
            ctrl1_r  <= `USD_ZERO8;
            int_en_r <= `USD_ZERO8;
            ctrl2_r  <= `USD_ZERO8;
            cnt_r    <= `USD_ZERO16;
        end else if (wr_now && !i_a0) begin
            addr_r <= i_data;
        end else if (wr_reg) begin
            case (addr_r)
                `USD_A_CTRL1:  ctrl1_r  <= i_data;
                `USD_A_INT_EN: int_en_r <= i_data;
                `USD_A_CTRL2:  ctrl2_r  <= i_data & `USD_CTRL2_MASK;
                `USD_A_CNT_LO: cnt_r[`USD_LO_BYTE] <= i_data;
                `USD_A_CNT_HI: cnt_r[`USD_HI_BYTE] <= i_data;
                default: ; // Frame registers are read only
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame capture on every SOF
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sof_lo_r  <= `USD_ZERO7;
            sof_hi_r  <= `USD_ZERO4;
            cur_set_r <= `USD_ZERO4;
        end else begin
            cur_set_r <= i_ep_set_sel;
            if (i_sof_seen) begin
                sof_lo_r <= i_sof_frame[`USD_FRM_LO];
                sof_hi_r <= i_sof_frame[`USD_FRM_HI];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // DMA engine: one byte per clock while acknowledge is held low
    always @* begin
        left_nxt    = left_r;
        dma_act_nxt = dma_act_r;
        dma_fin     = 1'b0;
        if (wr_reg && (addr_r == `USD_A_CNT_HI) && ctrl1_r[`USD_B_DMA_EN]) begin
            left_nxt    = {i_data, cnt_r[`USD_LO_BYTE]};
            dma_act_nxt = ({i_data, cnt_r[`USD_LO_BYTE]} != `USD_ZERO16);
            dma_fin     = ({i_data, cnt_r[`USD_LO_BYTE]} == `USD_ZERO16);
        end else if (dma_act_r && !ctrl1_r[`USD_B_DMA_EN]) begin
            dma_act_nxt = 1'b0; // Abort without done flag
        end else if (dma_act_r && !i_dma_ack_n) begin
            left_nxt = left_r - `USD_ONE16;
            if (left_r == `USD_ONE16) begin
                dma_act_nxt = 1'b0;
                dma_fin     = 1'b1;
            end
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_r    <= `USD_ZERO16;
            dma_act_r <= 1'b0;
        end else begin
            left_r    <= left_nxt;
            dma_act_r <= dma_act_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky flags, bits 6 down to 0
    assign flag_set = {1'b0, i_bus_reset_seen, i_sof_seen, dma_fin, i_ep_done};

    genvar g;
    generate
        for (g = 0; g < `USD_FLAG_N; g = g + 1) begin : g_flag
            usd_flag u_flag (
                .i_ref_clk (i_ref_clk),
                .i_rst_n   (i_rst_n),
                .i_set     (flag_set[g]),
                .i_clr     (stat_clr && i_data[g]),
                .o_flag    (flags[g])
            );
        end
    endgenerate

    assign status = {dma_act_r, flags};

    ////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits return zero
    always @* begin
        case (addr_r)
            `USD_A_CTRL1:    rd_val = ctrl1_r;
            `USD_A_INT_EN:   rd_val = int_en_r;
            `USD_A_INT_STAT: rd_val = status;
            `USD_A_CUR_SET:  rd_val = {`USD_ZERO4, cur_set_r};
            `USD_A_CTRL2:    rd_val = ctrl2_r;
            `USD_A_SOF_LO:   rd_val = {sof_lo_r, 1'b0};
            `USD_A_SOF_HI:   rd_val = {sof_hi_r, `USD_ZERO4};
            `USD_A_CNT_LO:   rd_val = cnt_r[`USD_LO_BYTE];
            `USD_A_CNT_HI:   rd_val = cnt_r[`USD_HI_BYTE];
            default:         rd_val = `USD_ZERO8;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data    <= `USD_ZERO8;
            o_data_oe <= 1'b0;
        end else begin
            // Drive the bus while read strobe is held
            o_data_oe <= !i_cs_n && !i_rd_n;
            if (rd_now) begin
                o_data <= i_a0 ? rd_val : addr_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs; bit 7 of enable is ignored so activity fall never interrupts
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_interrupt_request_out <= 1'b0;
            o_host_mode             <= 1'b0;
            o_line_swap             <= 1'b0;
            o_speed_select_bit      <= 1'b0;
            o_dma_req_n             <= 1'b1;
            o_dma_dir_read          <= 1'b0;
            o_endpoint_three_dma    <= 1'b0;
        end else begin
            o_interrupt_request_out <= |(flags & int_en_r[`USD_FLAGS]);
            o_host_mode             <= ctrl2_r[`USD_B_HOST];
            o_line_swap             <= ctrl2_r[`USD_B_SWAP];
            o_speed_select_bit      <= ctrl1_r[`USD_B_SPEED];
            o_dma_req_n             <= !dma_act_nxt;
            o_dma_dir_read          <= ctrl1_r[`USD_B_DMA_DIR];
            o_endpoint_three_dma    <= ctrl1_r[`USD_B_DMA_EN];
        end
    end
endmodule // usd_regs

// ### tb/usd_regs_chk.sv
`timescale 1ns/10ps
module usd_regs_chk (
    input wire       i_ref_clk,
    input wire       i_rst_n,
    input wire       i_cs_n,
    input wire       i_wr_n,
    input wire       i_a0,
    input wire       i_bus_reset_seen,
    input wire       i_sof_seen,
    input wire [3:0] i_ep_done,
    input wire       i_dma_ack_n,
    input wire       o_interrupt_request_out,
    input wire       o_host_mode,
    input wire       o_line_swap,
    input wire       o_dma_req_n,
    input wire       o_dma_dir_read,
    input wire       o_endpoint_three_dma
);
// Recent-cause windows, three cycles wide to absorb output register lag
reg  [2:0] w_r;
reg  [2:0] e_r;
wire w_hit = !i_cs_n && !i_wr_n && i_a0;
wire ev = i_sof_seen | i_bus_reset_seen | (|i_ep_done) | !i_dma_ack_n | w_hit;
always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        w_r <= 3'h0;
        e_r <= 3'h0;
    end else begin
        w_r <= {w_r[1:0], w_hit};
        e_r <= {e_r[1:0], ev};
    end
end
default clocking @(posedge i_ref_clk); endclocking
default disable iff (!i_rst_n);
host_role_a: assert property (
    !$stable(o_host_mode) |-> |w_r) else $error("Host role moved without write");
line_swap_a: assert property (
    !$stable(o_line_swap) |-> |w_r) else $error("Line swap moved without write");
dma_dir_a: assert property (
    !$stable(o_dma_dir_read) |-> |w_r) else $error("DMA direction moved without write");
ep_three_a: assert property (
    !$stable(o_endpoint_three_dma) |-> |w_r) else $error("Endpoint three mode moved");
dma_start_a: assert property (
    $fell(o_dma_req_n) |-> |w_r) else $error("DMA started without count write");
dma_hold_a: assert property (
    !o_dma_req_n && i_dma_ack_n && i_cs_n && $past(i_cs_n) |=> !o_dma_req_n)
    else $error("DMA ended with bytes left");
irq_rise_a: assert property (
    $rose(o_interrupt_request_out) |-> |e_r) else $error("Request rose without cause");
irq_fall_a: assert property (
    $fell(o_interrupt_request_out) |-> |w_r) else $error("Request fell without write");
endmodule // usd_regs_chk
bind usd_regs usd_regs_chk chk (.i_ref_clk, .i_rst_n, .i_cs_n, .i_wr_n, .i_a0,
    .i_bus_reset_seen, .i_sof_seen, .i_ep_done, .i_dma_ack_n, .o_interrupt_request_out,
    .o_host_mode, .o_line_swap, .o_dma_req_n, .o_dma_dir_read, .o_endpoint_three_dma);

// ### tb/usd_dma_peer.sv
`timescale 1ns/10ps
module usd_dma_peer (
    input wire i_clk,
    input wire i_stall,
    input wire i_req_n,
    output reg o_ack_n = 1'b1
);
// Stall lets the bench hold a transfer open to watch it in flight
always @(negedge i_clk) begin
    o_ack_n <= i_req_n | i_stall;
end
endmodule // usd_dma_peer

// ### tb/usd_regs_tb_top.sv
`timescale 1ns/10ps
`include "usd_regs_defs.vh"
module usd_regs_tb_top;
reg        clk = 0, rst_n = 0, cs_n = 1, wr_n = 1, rd_n = 1, a0 = 0;
reg        bus_rst = 0, sof = 0, stall = 1;
reg [7:0]  din = 8'h00, rv;
reg        rv_oe = 0;
reg [10:0] frame = 11'h000;
reg [3:0]  ep_done = 4'h0, ep_sel = 4'h0;
reg [15:0] nb = 16'h0000;
wire [7:0] dout;
wire       ack_n, irq, host, swap, req_n, dir, ep3, oe, spd;
integer    n_mismatch = 0, tests_run = 0, i;
////////////////////
usd_regs uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_a0(a0), .i_data(din), .i_bus_reset_seen(bus_rst), .i_sof_seen(sof), .i_sof_frame(frame),
    .i_ep_done(ep_done), .i_ep_set_sel(ep_sel), .i_dma_ack_n(ack_n), .o_data(dout),
    .o_data_oe(oe), .o_interrupt_request_out(irq), .o_host_mode(host), .o_line_swap(swap),
    .o_speed_select_bit(spd), .o_dma_req_n(req_n), .o_dma_dir_read(dir),
    .o_endpoint_three_dma(ep3));
usd_dma_peer peer (.i_clk(clk), .i_stall(stall), .i_req_n(req_n), .o_ack_n(ack_n));
initial forever #10 clk = ~clk;
always @(posedge clk) if (!ack_n) nb <= nb + 16'h0001;
task report_and_stop;
    begin
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end
endtask
task chk(input [8*6:1] nm, input [15:0] seen, input [15:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
        end
    end
endtask
// Strobes held two edges, then a free cycle so the next access sees a fresh edge
task acc(input a, input w, input [7:0] d);
    begin
        @(negedge clk);
        cs_n = 0;
        a0 = a;
        wr_n = !w;
        rd_n = w;
        din = d;
        repeat (2) @(negedge clk);
        rv = dout;
        rv_oe = oe;
        cs_n = 1;
        wr_n = 1;
        rd_n = 1;
        @(negedge clk);
    end
endtask
task wr(input [7:0] a, input [7:0] d);
    begin
        acc(0, 1, a);
        acc(1, 1, d);
    end
endtask
task rd(input [7:0] a, input [7:0] m, input [7:0] e, input [8*6:1] nm);
    begin
        acc(0, 1, a);
        acc(1, 0, 8'h00);
        chk(nm, {8'h00, rv & m}, {8'h00, e});
        // Bus driven while the read strobe stands, released after
        chk("oe", {14'h0000, rv_oe, oe}, 16'h0002);
    end
endtask
initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
end
initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    chk("req", {15'h0000, req_n}, 16'h0001);
    wr(`USD_A_CTRL2, 8'hff);
    rd(`USD_A_CTRL2, 8'hff, 8'hc0, "ctrl2");
    chk("role", {14'h0000, host, swap}, 16'h0003);
    wr(`USD_A_CTRL2, 8'h40);
    chk("role", {14'h0000, host, swap}, 16'h0001);
    ep_sel = 4'ha;
    rd(`USD_A_CUR_SET, 8'hff, 8'h0a, "curset");
    for (i = 0; i < 2; i = i + 1) begin
        frame = (i == 1) ? 11'h2b4 : 11'h5a5;
        @(negedge clk) sof = 1;
        @(negedge clk) sof = 0;
        // Frame registers are only ever read here, never written
        rd(`USD_A_SOF_LO, 8'hfe, {frame[6:0], 1'b0}, "sof_lo");
        rd(`USD_A_SOF_HI, 8'hf0, {frame[10:7], 4'h0}, "sof_hi");
    end
    @(negedge clk) {bus_rst, ep_done} = 5'h1f;
    @(negedge clk) {bus_rst, ep_done} = 5'h00;
    rd(`USD_A_INT_STAT, 8'hff, 8'h6f, "stat");
    wr(`USD_A_INT_EN, 8'h01);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd(`USD_A_INT_STAT, 8'hff, 8'h6f, "stat");
    wr(`USD_A_INT_STAT, 8'h21);
    rd(`USD_A_INT_STAT, 8'hff, 8'h4e, "stat");
    chk("irq", {15'h0000, irq}, 16'h0000);
    wr(`USD_A_INT_STAT, 8'hff);
    wr(`USD_A_CTRL1, 8'h00);
    wr(`USD_A_CNT_LO, 8'h02);
    wr(`USD_A_CNT_HI, 8'h01);
    rd(`USD_A_INT_STAT, 8'hff, 8'h00, "stat");
    wr(`USD_A_INT_EN, 8'h80);
    wr(`USD_A_CTRL1, 8'h26);
    chk("ctrl1", {13'h0000, dir, ep3, spd}, 16'h0007);
    wr(`USD_A_CNT_LO, 8'h02);
    wr(`USD_A_CNT_HI, 8'h01);
    rd(`USD_A_INT_STAT, 8'hff, 8'h80, "stat");
    chk("req", {15'h0000, req_n}, 16'h0000);
    // Activity bit is set and enabled, yet must not request
    chk("irq", {15'h0000, irq}, 16'h0000);
    rd(`USD_A_CNT_LO, 8'hff, 8'h02, "cnt_lo");
    rd(`USD_A_CNT_HI, 8'hff, 8'h01, "cnt_hi");
    stall = 0;
    for (i = 0; i < 400 && req_n !== 1'b1; i = i + 1) @(negedge clk);
    chk("bytes", nb, 16'h0102);
    rd(`USD_A_INT_STAT, 8'hff, 8'h10, "stat");
    chk("irq", {15'h0000, irq}, 16'h0000);
    report_and_stop;
end
endmodule // usd_regs_tb_top
